// file: core/gpa_map.svh
// Address map and constants for the port A I/O block
// Assumes an 8-bit processor bus with a 16-bit address, single-cycle access
`ifndef GPA_MAP_SVH
`define GPA_MAP_SVH

//------------------------------------------------------------
// Register addresses
//------------------------------------------------------------
`define GPA_ADDR_DATA      16'h0000
`define GPA_ADDR_DIR       16'h0004
`define GPA_ADDR_PULLUP    16'h000d

//------------------------------------------------------------
// Reset values and field sizes
//------------------------------------------------------------
`define GPA_DIR_RST        8'h00
`define GPA_PULLUP_RST     8'h00
`define GPA_ZERO_BYTE      8'h00
`define GPA_CHAN_LO        5'h08
`define GPA_CHAN_HI        5'h0f

`endif

// file: core/gpa_pkg.sv
// Types shared by the port A I/O block
// Assumes the address map header sits beside it
package gpa_pkg;
	typedef logic [7:0]  gpa_byte_t;
	typedef logic [15:0] gpa_addr_t;
	typedef logic [4:0]  gpa_chan_t;
endpackage

// file: core/gpa_port_a.sv
// Port A I/O logic: data latch, direction, pullup enable, pin sharing
// Assumes pins are resolved outside from out, oe and pullup enables
`timescale 1ns/1ps
`include "gpa_map.svh"

module gpa_port_a
	import gpa_pkg::*;
(
	input  wire logic      sys_clk,
	input  wire logic      srst,
	input  wire gpa_addr_t bus_addr,
	input  wire logic      bus_wr,
	input  wire logic      bus_rd,
	input  wire gpa_byte_t bus_wdata,
	output gpa_byte_t      bus_rdata,
	input  wire gpa_byte_t pin_in,
	output gpa_byte_t      pin_out,
	output gpa_byte_t      pin_oe,
	output gpa_byte_t      pin_pullup_on,
	output gpa_byte_t      pin_analog_sel,
	input  wire gpa_byte_t keypad_irq_enable_bits,
	output gpa_byte_t      keypad_input_pins,
	input  wire logic      converter_enable,
	input  wire gpa_chan_t converter_channel_select
);

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	gpa_byte_t port_a_latch_bits_ff;
	gpa_byte_t nxt_port_a_latch_bits;
	gpa_byte_t port_a_direction_bits_ff;
	gpa_byte_t nxt_port_a_direction_bits;
	gpa_byte_t port_a_pullup_enable_ff;
	gpa_byte_t nxt_port_a_pullup_enable;
	// Pin synchroniser stages
	gpa_byte_t pin_meta_ff;
	gpa_byte_t nxt_pin_meta;
	gpa_byte_t pin_sync_ff;
	gpa_byte_t nxt_pin_sync;
	// Read data and keypad level
	gpa_byte_t rdata_ff;
	gpa_byte_t nxt_rdata;
	gpa_byte_t keypad_pins_ff;
	gpa_byte_t nxt_keypad_pins;
	// Decoded strobes and pin control terms
	logic      wr_data_hit;
	logic      wr_dir_hit;
	logic      wr_pullup_hit;
	gpa_byte_t analog_sel;
	gpa_byte_t digital_oe;
	gpa_byte_t digital_pullup;

	//------------------------------------------------------------
	// Helper functions
	//------------------------------------------------------------
	// Decode one analog channel onto a pin mask
	function automatic gpa_byte_t chan_to_mask(input logic en, input gpa_chan_t ch);
		gpa_byte_t m;
		m = `GPA_ZERO_BYTE;
		if (en && ch >= `GPA_CHAN_LO && ch <= `GPA_CHAN_HI)
		begin
			m[3'(ch - `GPA_CHAN_LO)] = 1'b1;
		end
		return m;
	endfunction

	// Write strobe aimed at one register address
	function automatic logic wr_hit(
		input logic      wr,
		input gpa_addr_t addr,
		input gpa_addr_t target
	);
		logic hit;
		hit = wr && (addr == target);
		return hit;
	endfunction

	// outputs read latch, inputs read pin
	function automatic gpa_byte_t port_read(
		input gpa_byte_t dir,
		input gpa_byte_t latch,
		input gpa_byte_t pin
	);
		gpa_byte_t val;
		val = (dir & latch) | (~dir & pin);
		return val;
	endfunction

	//------------------------------------------------------------
	// Pin sampling
	//------------------------------------------------------------
	// Two stages since pins are asynchronous to sys_clk
	always_comb
	begin
		nxt_pin_meta = pin_in;
		nxt_pin_sync = pin_meta_ff;
	end

	// Only the second stage is read by logic
	always_ff @(posedge sys_clk)
	begin
		pin_meta_ff <= nxt_pin_meta;
		pin_sync_ff <= nxt_pin_sync;
	end

	//------------------------------------------------------------
	// Address decode
	//------------------------------------------------------------
	// One strobe per writable register
	assign wr_data_hit   = wr_hit(bus_wr, bus_addr, `GPA_ADDR_DATA);
	assign wr_dir_hit    = wr_hit(bus_wr, bus_addr, `GPA_ADDR_DIR);
	assign wr_pullup_hit = wr_hit(bus_wr, bus_addr, `GPA_ADDR_PULLUP);

	//------------------------------------------------------------
	// Register file
	//------------------------------------------------------------
	// Next values of the software registers, reset folded in for direction and pullup only; the data latch keeps its value
	always_comb
	begin
		nxt_port_a_latch_bits     = port_a_latch_bits_ff;
		nxt_port_a_direction_bits = port_a_direction_bits_ff;
		nxt_port_a_pullup_enable  = port_a_pullup_enable_ff;
		if (wr_data_hit)
		begin
			nxt_port_a_latch_bits = bus_wdata;
		end
		if (wr_dir_hit)
		begin
			nxt_port_a_direction_bits = bus_wdata;
		end
		if (wr_pullup_hit)
		begin
			nxt_port_a_pullup_enable = bus_wdata;
		end
		if (srst)
		begin
			nxt_port_a_direction_bits = `GPA_DIR_RST;
			nxt_port_a_pullup_enable  = `GPA_PULLUP_RST;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		port_a_latch_bits_ff     <= nxt_port_a_latch_bits;
		port_a_direction_bits_ff <= nxt_port_a_direction_bits;
		port_a_pullup_enable_ff  <= nxt_port_a_pullup_enable;
	end

	//------------------------------------------------------------
	// Read path
	//------------------------------------------------------------
	// Read data registered; unmapped addresses read zero
	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (bus_rd)
		begin
			case (bus_addr)
				`GPA_ADDR_DATA:
				begin
					nxt_rdata = port_read(port_a_direction_bits_ff, port_a_latch_bits_ff,
						pin_sync_ff);
				end
				`GPA_ADDR_DIR:
				begin
					nxt_rdata = port_a_direction_bits_ff;
				end
				`GPA_ADDR_PULLUP:
				begin
					nxt_rdata = port_a_pullup_enable_ff;
				end
				default:
				begin
					nxt_rdata = `GPA_ZERO_BYTE;
				end
			endcase
		end
		// Reset wins over a read in the same cycle
		if (srst)
		begin
			nxt_rdata = `GPA_ZERO_BYTE;
		end
	end

	// Holds the last read value until the next read or a reset
	always_ff @(posedge sys_clk)
	begin
		rdata_ff <= nxt_rdata;
	end

	assign bus_rdata = rdata_ff;

	//------------------------------------------------------------
	// Pin control
	//------------------------------------------------------------
	// converter selection overrides digital control
	assign analog_sel = chan_to_mask(converter_enable, converter_channel_select);

	// Digital terms before the analog override
	always_comb
	begin
		digital_oe = port_a_direction_bits_ff;
		digital_pullup = port_a_pullup_enable_ff & ~port_a_direction_bits_ff;
	end

	assign pin_oe         = digital_oe & ~analog_sel;
	assign pin_pullup_on  = digital_pullup & ~analog_sel;
	assign pin_analog_sel = analog_sel;
	// Latch always on pin_out; the pad gates it with oe
	assign pin_out        = port_a_latch_bits_ff;

	//------------------------------------------------------------
	// Keypad path
	//------------------------------------------------------------
	// enabled pins feed keypad
	always_comb
	begin
		nxt_keypad_pins = keypad_irq_enable_bits & pin_sync_ff;
	end

	// Registered so the keypad sees a flop, at one cycle of lag
	always_ff @(posedge sys_clk)
	begin
		keypad_pins_ff <= nxt_keypad_pins;
	end

	assign keypad_input_pins = keypad_pins_ff;

endmodule // gpa_port_a

// file: bench/gpa_port_a_sva.sv
// Port A checker on the block's ports
// Assumes the map header on the include path
`timescale 1ns/1ps
`include "gpa_map.svh"
module gpa_port_a_sva import gpa_pkg::*; (
	input wire logic      sys_clk, srst, bus_wr, bus_rd, converter_enable,
	input wire gpa_addr_t bus_addr,
	input wire gpa_chan_t converter_channel_select,
	input wire gpa_byte_t bus_wdata, bus_rdata, pin_in, pin_out, pin_oe, pin_pullup_on,
	input wire gpa_byte_t pin_analog_sel, keypad_irq_enable_bits, keypad_input_pins
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	property p_rst; disable iff (1'b0) srst |=> !(pin_oe | pin_pullup_on); endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_dir; bus_wr && bus_addr == `GPA_ADDR_DIR
		|=> converter_enable || pin_oe == $past(bus_wdata); endproperty
	a_dir: assert property (p_dir) else $error("dir");
	property p_dat; bus_wr && bus_addr == `GPA_ADDR_DATA |=> pin_out == $past(bus_wdata); endproperty
	a_dat: assert property (p_dat) else $error("latch");
	property p_pu; !(pin_oe & pin_pullup_on); endproperty
	a_pu: assert property (p_pu) else $error("pullup");
	property p_an; !((pin_oe | pin_pullup_on) & pin_analog_sel); endproperty
	a_an: assert property (p_an) else $error("analog");
	property p_sel; pin_analog_sel == (converter_enable && converter_channel_select[4:3] == 2'b01
		? 8'h01 << converter_channel_select[2:0] : 8'h00); endproperty
	a_sel: assert property (p_sel) else $error("sel");
	property p_kb; keypad_input_pins
		== ($past(keypad_irq_enable_bits) & $past(pin_in, 3)); endproperty
	a_kb: assert property (p_kb) else $error("keypad");
	property p_rd; bus_rd && bus_addr == `GPA_ADDR_DATA && pin_oe == 8'hff
		|=> bus_rdata == $past(pin_out); endproperty
	a_rd: assert property (p_rd) else $error("read");
	property p_rdin; bus_rd && bus_addr == `GPA_ADDR_DATA && !converter_enable && pin_oe == 8'h00
		|=> bus_rdata == $past(pin_in, 3); endproperty
	a_rdin: assert property (p_rdin) else $error("read pin");
endmodule // gpa_port_a_sva
bind gpa_port_a gpa_port_a_sva chk (
	.sys_clk                  (sys_clk),
	.srst                     (srst),
	.bus_wr                   (bus_wr),
	.bus_rd                   (bus_rd),
	.converter_enable         (converter_enable),
	.bus_addr                 (bus_addr),
	.converter_channel_select (converter_channel_select),
	.bus_wdata                (bus_wdata),
	.bus_rdata                (bus_rdata),
	.pin_in                   (pin_in),
	.pin_out                  (pin_out),
	.pin_oe                   (pin_oe),
	.pin_pullup_on            (pin_pullup_on),
	.pin_analog_sel           (pin_analog_sel),
	.keypad_irq_enable_bits   (keypad_irq_enable_bits),
	.keypad_input_pins        (keypad_input_pins)
);

// file: bench/gpa_pin_model.sv
// Pin model: outside drive, pullup or float
`timescale 1ns/1ps
module gpa_pin_model import gpa_pkg::*; (
	input wire logic      sys_clk,
	input wire gpa_byte_t pin_out, pin_oe, pin_pullup_on, ext_lvl, ext_drv,
	output gpa_byte_t     pin_in
);
	gpa_byte_t flt_ff = 8'h5a; // Float toggles, never holds
	always @(posedge sys_clk) flt_ff <= ~flt_ff;
	assign pin_in = pin_oe & pin_out
		| ~pin_oe & (ext_drv & ext_lvl | ~ext_drv & (pin_pullup_on | flt_ff));
endmodule // gpa_pin_model

// file: bench/bidirectional_port_a_io_tb.sv
// Bench: random register and pin traffic for port A
// Assumes design, package and pin model compiled first
`timescale 1ns/1ps
`include "gpa_map.svh"
module bidirectional_port_a_io_tb import gpa_pkg::*; ;
	logic sys_clk = 0, srst = 1, bus_wr = 0, bus_rd = 0, converter_enable = 0;
	gpa_addr_t bus_addr = 0;
	gpa_chan_t converter_channel_select = 0;
	gpa_byte_t bus_wdata = 0, keypad_irq_enable_bits = 0, ext_lvl = 0, ext_drv = 0, w, d, p, s, v;
	gpa_byte_t bus_rdata, pin_in, pin_out, pin_oe, pin_pullup_on, pin_analog_sel, keypad_input_pins;
	int miscompares = 0, tests_run = 0, cyc = 0;
	logic [31:0] rng = 49352;
	gpa_port_a uut (.*);
	gpa_pin_model pm (.*);
	initial forever #10 sys_clk = ~sys_clk;
	function automatic gpa_byte_t rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction
	function automatic gpa_byte_t sel(gpa_chan_t c);
		return (converter_enable && c >= `GPA_CHAN_LO && c <= `GPA_CHAN_HI) ? 8'h01 << c[2:0] : 8'h00;
	endfunction
	task automatic chk(string n, gpa_byte_t g, gpa_byte_t e);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// One bus access, held across its taking edge
	task automatic acc(logic r, gpa_addr_t a, gpa_byte_t x);
		@(negedge sys_clk);
		{bus_rd, bus_wr, bus_addr, bus_wdata} = {r, !r, a, x};
		@(negedge sys_clk);
		{bus_rd, bus_wr} = 2'b00;
	endtask
	task automatic stop_test();
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge sys_clk)
		if (++cyc == 3000)
		begin
			miscompares++;
			stop_test();
		end
	initial
	begin
		repeat (3) @(negedge sys_clk);
		srst = 0;
		for (int i = 0; i < 24; i++)
		begin
			{w, p, s} = {rnd(), rnd(), rnd()};
			// Corner channels: one selected pin, one out of range
			s[5:0] = (i == 2) ? 6'h2b : (i == 3) ? 6'h27 : s[5:0];
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd();
			keypad_irq_enable_bits = i ? rnd() : 8'h00;
			{converter_enable, ext_lvl, ext_drv} = {1'b0, rnd(), ~p};
			acc(1'b0, `GPA_ADDR_DATA, w);
			acc(1'b0, `GPA_ADDR_PULLUP, p);
			acc(1'b0, `GPA_ADDR_DIR, d);
			repeat (3) @(negedge sys_clk);
			acc(1'b1, `GPA_ADDR_DATA, 8'h00);
			v = w & d | ~d & (p | ext_lvl);
			chk("rd", bus_rdata, v);
			chk("oe", pin_oe, d);
			chk("pu", pin_pullup_on, p & ~d);
			chk("latch", pin_out, w);
			chk("kbd", keypad_input_pins, v & keypad_irq_enable_bits);
			{converter_enable, converter_channel_select} = s[5:0];
			@(negedge sys_clk);
			chk("an", pin_analog_sel, sel(converter_channel_select));
			chk("an_oe", pin_oe, d & ~sel(converter_channel_select));
			chk("an_pu", pin_pullup_on, p & ~d & ~sel(converter_channel_select));
		end
		acc(1'b1, 16'h0001, 8'h00);
		chk("unmap", bus_rdata, `GPA_ZERO_BYTE);
		srst = 1;
		@(negedge sys_clk);
		srst = 0;
		chk("latch_rst", pin_out, w);
		chk("oe_rst", pin_oe, `GPA_DIR_RST);
		stop_test();
	end
endmodule // bidirectional_port_a_io_tb
